// file: core/llh_pkg.sv
/*
  Package for the link-loss holdover controller: timing counts, register map,
  PLL write addresses, state enumeration and state carriers.
  Assumes a single 25 MHz reference clock drives every user of these constants.
*/
package llh_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ    = 25;
	localparam int RXOFF_US   = 100;
	localparam int RXON_MS    = 4;
	localparam int VERIFY_US  = 200;
	localparam int MON_US     = 10;
	localparam int RXOFF_CYC  = RXOFF_US * CLK_MHZ;
	localparam int RXON_CYC   = RXON_MS * 1000 * CLK_MHZ;
	localparam int VERIFY_CYC = VERIFY_US * CLK_MHZ;
	localparam int MON_CYC    = MON_US * CLK_MHZ;
	localparam int CNT_W      = 17;
	localparam int WATCH_W    = 3;
	localparam logic [7:0] MON_LAST = 8'(MON_CYC - 1);

	// ----------------------------------------------------------------
	// APB register map
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] MON_LO_OFS = 8'h08;
	localparam logic [7:0] MON_HI_OFS = 8'h0c;
	localparam int CTRL_EN_BIT  = 0;
	localparam int CTRL_AVG_BIT = 1;
	localparam logic        CTRL_EN_RST  = 1'b1;
	localparam logic        CTRL_AVG_RST = 1'b0;
	localparam logic [15:0] MON_LO_RST   = 16'h00f0;
	localparam logic [15:0] MON_HI_RST   = 16'h0110;

	// ----------------------------------------------------------------
	// PLL side register writes
	// ----------------------------------------------------------------
	localparam logic [15:0] HOLD_CTRL_ADDR = 16'h0020;
	localparam logic [15:0] DES_PR_ADDR    = 16'h0040;
	localparam int HOLD_BIT   = 0;
	localparam int PRESET_BIT = 1;
	localparam int RXPD_BIT   = 0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		S_IDLE, S_HOLD_WR, S_RXOFF_WR, S_RXOFF_WAIT, S_RXON_WR,
		S_RXON_WAIT, S_LOCK_SAMPLE, S_LOCK_VERIFY, S_LEAVE_WR
	} llh_state_t;

	typedef struct packed {
		logic        req;
		logic [15:0] addr;
		logic [31:0] data;
	} llh_pllwr_t;

	typedef struct packed {
		llh_state_t       state;
		logic             pready;
		logic             pslverr;
		logic [31:0]      prdata;
		logic             ctrl_en;
		logic             ctrl_avg;
		logic [15:0]      mon_lo;
		logic [15:0]      mon_hi;
		logic [7:0]       mon_cyc;
		logic [15:0]      mon_ticks;
		logic             link_down;
		logic             pll_hold;
		logic             rx_off;
		logic             avg_run;
		llh_pllwr_t       wr;
		logic             tmr_start;
		logic [CNT_W-1:0] tmr_limit;
	} llh_core_t;

	typedef struct packed {
		logic             run;
		logic             ok;
		logic             done;
		logic [CNT_W-1:0] cnt;
	} llh_tmr_t;

endpackage

// file: core/llh_window_timer.sv
/*
  Stability window timer: counts a loaded number of cycles and reports whether
  every watched signal stayed high for the whole window.
  Assumes start is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/1ps
module llh_window_timer import llh_pkg::*; (
	input  wire logic               i_clk,
	input  wire logic               i_srst,
	input  wire logic               i_start,
	input  wire logic [CNT_W-1:0]   i_limit,
	input  wire logic [WATCH_W-1:0] i_watch,
	output logic                    o_done,
	output logic                    o_stable
);
	llh_tmr_t st;
	llh_tmr_t next_st;

	// ----------------------------------------------------------------
	// Window counter
	// ----------------------------------------------------------------
	always_comb begin
		next_st      = st;
		next_st.done = 1'b0;
		if (i_start) begin
			next_st.run = 1'b1;
			next_st.ok  = &i_watch;
			next_st.cnt = i_limit - 1'b1;
		end else if (st.run) begin
			if (!(&i_watch)) begin
				next_st.ok = 1'b0;
			end
			if (st.cnt == '0) begin
				next_st.run  = 1'b0;
				next_st.done = 1'b1;
			end else begin
				next_st.cnt = st.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_done   = st.done;
	assign o_stable = st.ok;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	a_drop_spoils_window: assert property (st.run && !i_start && !(&i_watch) |=> !st.ok)
		else $error("Watched drop did not spoil the window.");
	a_done_after_count: assert property (st.run && !i_start && st.cnt == '0 |=> o_done && !st.run)
		else $error("Window did not end when the count ran out.");
endmodule

// file: core/llh_holdover_ctrl.sv
/*
  Link-loss holdover controller: enters PLL holdover on a lost source link,
  cycles the receiver power until the link comes back, confirms PLL frequency
  lock and leaves holdover; includes the recovered-clock frequency monitor and
  an APB register slave.
  Assumes all inputs are synchronous to I_REF_CLK and the PLL write port
  acknowledges each request with a one-cycle I_PLL_WR_ACK.
*/
// Contract
// - Frequency monitor raises link status when recovered clock leaves its limits.
// - No-source-link sets hold and preset select, then go to receiver-off.
// - Power receiver down and up repeatedly until the link is confirmed.
// - Keep receiver off 100 us, then go to receiver-on.
// - In receiver-on, watch ready, lane lock and link status for 4 ms.
// - All stable at window end goes to lock-sample, else back to receiver-off.
// - After link is confirmed, read frequency lock then check it stays stable.
// - Lock stable 200 us goes to leave-hold, else back to lock-sample.
// - Leave-hold clears hold and preset select to release the PLL.
// - Hold and preset select change through writes to the hold-control register.
// - Receiver power changes through writes to the deserializer power-reset register.
// - Preset averaging stops whenever the link breaks.
// - Controller and register-write path share one clock.
`timescale 1ns/1ps
module llh_holdover_ctrl import llh_pkg::*; #(
	parameter int RXON_CYCLES   = RXON_CYC,
	parameter int VERIFY_CYCLES = VERIFY_CYC
) (
	input  wire logic        I_REF_CLK,
	input  wire logic        I_SRST,
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [7:0]  I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	input  wire logic        I_NO_SOURCE_LINK,
	input  wire logic        I_RCLK_TICK,
	input  wire logic        I_RX_READY,
	input  wire logic        I_LANE_LOCK,
	input  wire logic        I_PLL_FLOCK,
	input  wire logic        I_PLL_WR_ACK,
	output logic             O_PLL_WR_REQ,
	output logic      [15:0] O_PLL_WR_ADDR,
	output logic      [31:0] O_PLL_WR_DATA,
	output logic             O_PLL_HOLD,
	output logic             O_RX_OFF,
	output logic             O_LINK_DOWN,
	output logic             O_AVG_RUN
);
	llh_core_t          st;
	llh_core_t          next_st;
	logic               tmr_done;
	logic               tmr_stable;
	logic [WATCH_W-1:0] watch;
	logic               wr_ack;
	logic               apb_setup;
	logic               apb_take;

	// ----------------------------------------------------------------
	// Stability window
	// ----------------------------------------------------------------
	always_comb begin
		if (st.state == S_LOCK_VERIFY) begin
			watch = {I_PLL_FLOCK, 2'b11};
		end else begin
			watch = {I_RX_READY, I_LANE_LOCK, ~st.link_down};
		end
	end

	llh_window_timer i_llh_window_timer (
		.i_clk    (I_REF_CLK),
		.i_srst   (I_SRST),
		.i_start  (st.tmr_start),
		.i_limit  (st.tmr_limit),
		.i_watch  (watch),
		.o_done   (tmr_done),
		.o_stable (tmr_stable)
	);

	assign wr_ack    = st.wr.req & I_PLL_WR_ACK;
	assign apb_setup = I_PSEL & I_PENABLE & ~st.pready;
	assign apb_take  = I_PSEL & I_PENABLE & st.pready;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st           = st;
		next_st.tmr_start = 1'b0;

		// APB slave: one wait state, data and error registered.
		next_st.pready = apb_setup;
		if (apb_setup) begin
			next_st.pslverr = 1'b0;
			case (I_PADDR)
				CTRL_OFS: begin
					next_st.prdata = {30'h0000_0000, st.ctrl_avg, st.ctrl_en};
				end
				STATUS_OFS: begin
					next_st.prdata = {23'h00_0000, I_PLL_FLOCK, st.avg_run, st.link_down,
						st.rx_off, st.pll_hold, st.state};
				end
				MON_LO_OFS: begin
					next_st.prdata = {16'h0000, st.mon_lo};
				end
				MON_HI_OFS: begin
					next_st.prdata = {16'h0000, st.mon_hi};
				end
				default: begin
					next_st.prdata  = 32'h0000_0000;
					next_st.pslverr = 1'b1;
				end
			endcase
		end
		if (apb_take && I_PWRITE) begin
			case (I_PADDR)
				CTRL_OFS: begin
					next_st.ctrl_en  = I_PWDATA[CTRL_EN_BIT];
					next_st.ctrl_avg = I_PWDATA[CTRL_AVG_BIT];
				end
				MON_LO_OFS: begin
					next_st.mon_lo = I_PWDATA[15:0];
				end
				MON_HI_OFS: begin
					next_st.mon_hi = I_PWDATA[15:0];
				end
				default: begin
					next_st.mon_lo = st.mon_lo;
				end
			endcase
		end

		// Frequency monitor: recovered-clock ticks per fixed interval.
		if (st.mon_cyc == MON_LAST) begin
			next_st.mon_cyc   = 8'h00;
			next_st.mon_ticks = 16'h0000;
			next_st.link_down = (st.mon_ticks < st.mon_lo) | (st.mon_ticks > st.mon_hi);
		end else begin
			next_st.mon_cyc   = st.mon_cyc + 8'h01;
			next_st.mon_ticks = st.mon_ticks + {15'h0000, I_RCLK_TICK};
		end

		// Averaging runs only while the link is whole.
		next_st.avg_run = st.ctrl_avg & ~st.pll_hold & ~st.link_down & ~I_NO_SOURCE_LINK;

		if (wr_ack) begin
			next_st.wr.req = 1'b0;
		end

		case (st.state)
			S_IDLE: begin
				if (st.ctrl_en && I_NO_SOURCE_LINK) begin
					next_st.wr    = '{1'b1, HOLD_CTRL_ADDR, 32'h0000_0003};
					next_st.state = S_HOLD_WR;
				end
			end
			S_HOLD_WR: begin
				if (wr_ack) begin
					next_st.pll_hold = 1'b1;
					next_st.wr       = '{1'b1, DES_PR_ADDR, 32'h0000_0001};
					next_st.state    = S_RXOFF_WR;
				end
			end
			S_RXOFF_WR: begin
				if (wr_ack) begin
					next_st.rx_off    = 1'b1;
					next_st.tmr_start = 1'b1;
					next_st.tmr_limit = CNT_W'(RXOFF_CYC);
					next_st.state     = S_RXOFF_WAIT;
				end
			end
			S_RXOFF_WAIT: begin
				if (tmr_done) begin
					next_st.wr    = '{1'b1, DES_PR_ADDR, 32'h0000_0000};
					next_st.state = S_RXON_WR;
				end
			end
			S_RXON_WR: begin
				if (wr_ack) begin
					next_st.rx_off    = 1'b0;
					next_st.tmr_start = 1'b1;
					next_st.tmr_limit = CNT_W'(RXON_CYCLES);
					next_st.state     = S_RXON_WAIT;
				end
			end
			S_RXON_WAIT: begin
				if (tmr_done && tmr_stable) begin
					next_st.state = S_LOCK_SAMPLE;
				end else if (tmr_done) begin
					next_st.wr    = '{1'b1, DES_PR_ADDR, 32'h0000_0001};
					next_st.state = S_RXOFF_WR;
				end
			end
			S_LOCK_SAMPLE: begin
				if (I_PLL_FLOCK) begin
					next_st.tmr_start = 1'b1;
					next_st.tmr_limit = CNT_W'(VERIFY_CYCLES);
					next_st.state     = S_LOCK_VERIFY;
				end
			end
			S_LOCK_VERIFY: begin
				if (tmr_done && tmr_stable) begin
					next_st.wr    = '{1'b1, HOLD_CTRL_ADDR, 32'h0000_0000};
					next_st.state = S_LEAVE_WR;
				end else if (tmr_done) begin
					next_st.state = S_LOCK_SAMPLE;
				end
			end
			S_LEAVE_WR: begin
				if (wr_ack) begin
					next_st.pll_hold = 1'b0;
					next_st.state    = S_IDLE;
				end
			end
			default: begin
				next_st.state = S_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge I_REF_CLK) begin
		if (I_SRST) begin
			st          <= '0;
			st.ctrl_en  <= CTRL_EN_RST;
			st.ctrl_avg <= CTRL_AVG_RST;
			st.mon_lo   <= MON_LO_RST;
			st.mon_hi   <= MON_HI_RST;
		end else begin
			st <= next_st;
		end
	end

	assign O_PRDATA      = st.prdata;
	assign O_PREADY      = st.pready;
	assign O_PSLVERR     = st.pslverr;
	assign O_PLL_WR_REQ  = st.wr.req;
	assign O_PLL_WR_ADDR = st.wr.addr;
	assign O_PLL_WR_DATA = st.wr.data;
	assign O_PLL_HOLD    = st.pll_hold;
	assign O_RX_OFF      = st.rx_off;
	assign O_LINK_DOWN   = st.link_down;
	assign O_AVG_RUN     = st.avg_run;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (I_SRST);

	a_hold_entry_write: assert property (st.state == S_IDLE && st.ctrl_en && I_NO_SOURCE_LINK
		|=> O_PLL_WR_REQ && O_PLL_WR_ADDR == HOLD_CTRL_ADDR && O_PLL_WR_DATA[1:0] == 2'b11)
		else $error("Holdover entry write missing or wrong.");
	a_hold_then_rxoff: assert property (st.state == S_HOLD_WR && wr_ack
		|=> O_PLL_HOLD && st.state == S_RXOFF_WR && O_PLL_WR_ADDR == DES_PR_ADDR)
		else $error("Hold acknowledge did not lead to receiver power-down.");
	a_rxoff_power_down: assert property (st.state == S_RXOFF_WR |-> O_PLL_WR_DATA[RXPD_BIT])
		else $error("Receiver power-down write carries wrong data.");
	a_rxoff_dwell: assert property (st.state == S_RXOFF_WR && wr_ack
		|=> st.state == S_RXOFF_WAIT [*8] ##1 st.state == S_RXOFF_WAIT)
		else $error("Receiver-off dwell ended too early.");
	a_rxon_fail_back: assert property (st.state == S_RXON_WAIT && tmr_done && !tmr_stable
		|=> st.state == S_RXOFF_WR && O_PLL_WR_DATA[RXPD_BIT])
		else $error("Unstable receiver window did not power down again.");
	a_rxon_pass: assert property (st.state == S_RXON_WAIT && tmr_done && tmr_stable
		|=> st.state == S_LOCK_SAMPLE)
		else $error("Stable receiver window did not advance.");
	a_verify_fail_back: assert property (st.state == S_LOCK_VERIFY && tmr_done && !tmr_stable
		|=> st.state == S_LOCK_SAMPLE)
		else $error("Lost lock did not return to sampling.");
	a_leave_release: assert property (st.state == S_LEAVE_WR && wr_ack
		|=> !O_PLL_HOLD && st.state == S_IDLE && $past(O_PLL_WR_DATA[1:0]) == 2'b00)
		else $error("Leaving holdover did not clear hold.");
	a_avg_stops: assert property ((O_LINK_DOWN || O_PLL_HOLD) |=> !O_AVG_RUN)
		else $error("Averaging kept running on a broken link.");
	a_monitor_flags: assert property (st.mon_cyc == MON_LAST && st.mon_ticks < st.mon_lo
		|=> O_LINK_DOWN ##1 O_LINK_DOWN)
		else $error("Frequency deviation did not raise link status.");

	c_full_recovery: cover property (st.state == S_LEAVE_WR && wr_ack);
	c_rxon_retry: cover property (st.state == S_RXON_WAIT && tmr_done && !tmr_stable);
	c_verify_retry: cover property (st.state == S_LOCK_VERIFY && tmr_done && !tmr_stable);
	c_apb_error: cover property (O_PREADY && O_PSLVERR);
endmodule

// file: sim/llh_pll_model.sv
/*
  Partner model of the PLL register write port: acknowledges each write,
  promptly and after three cycles in turn, and keeps the bits written.
  Assumes the requester holds request, address and data until acknowledge.
*/
`timescale 1ns/1ps
module llh_pll_model import llh_pkg::*; (
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	input  wire logic        i_req,
	input  wire logic [15:0] i_addr,
	input  wire logic [31:0] i_data,
	output logic             o_ack,
	output logic      [7:0]  o_wr_cnt,
	output logic      [15:0] o_last_addr,
	output logic      [31:0] o_last_data,
	output logic      [1:0]  o_hold_word,
	output logic             o_rx_pd
);
	logic       slow;
	logic [1:0] wait_cnt;

	always @(posedge i_clk) begin
		o_ack <= 1'b0;
		if (i_srst) begin
			{slow, wait_cnt, o_wr_cnt, o_hold_word, o_rx_pd} <= '0;
		end else if (i_req && !o_ack) begin
			wait_cnt <= wait_cnt + 2'h1;
			if (wait_cnt == {slow, slow}) begin
				o_ack       <= 1'b1;
				wait_cnt    <= 2'h0;
				slow        <= !slow;
				o_wr_cnt    <= o_wr_cnt + 8'h01;
				o_last_addr <= i_addr;
				o_last_data <= i_data;
				if (i_addr == HOLD_CTRL_ADDR) o_hold_word <= i_data[1:0];
				if (i_addr == DES_PR_ADDR) o_rx_pd <= i_data[RXPD_BIT];
			end
		end
	end
endmodule

// file: sim/llh_holdover_ctrl_tb.sv
/*
  Self-checking bench for the holdover controller: registers over APB,
  frequency monitor low limit, and the full loss and recovery sequence.
  Assumes the PLL model answers the write port and shorter window counts.
*/
`timescale 1ns/1ps
module llh_holdover_ctrl_tb import llh_pkg::*;;
	localparam int RXON_T = 40;
	localparam int VER_T  = 20;
	localparam int LIMIT  = 30000;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        nsl = 1'b0;
	logic        tick = 1'b1;
	logic        rx_ready = 1'b1;
	logic        lane_lock = 1'b1;
	logic        flock = 1'b0;
	logic [31:0] prdata, wr_data, last_data, rd;
	logic [15:0] wr_addr, last_addr;
	logic [7:0]  wr_cnt, n;
	logic [1:0]  hold_word;
	logic        pready, pslverr, ack, wr_req, pll_hold, rx_off, link_down, avg_run, rx_pd, err;
	int          mismatches = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          c;

	always #20 clk = ~clk;

	llh_holdover_ctrl #(.RXON_CYCLES(RXON_T), .VERIFY_CYCLES(VER_T)) i_llh_holdover_ctrl (
		.I_REF_CLK(clk), .I_SRST(srst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
		.I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.I_NO_SOURCE_LINK(nsl), .I_RCLK_TICK(tick), .I_RX_READY(rx_ready), .I_LANE_LOCK(lane_lock),
		.I_PLL_FLOCK(flock), .I_PLL_WR_ACK(ack), .O_PLL_WR_REQ(wr_req), .O_PLL_WR_ADDR(wr_addr),
		.O_PLL_WR_DATA(wr_data), .O_PLL_HOLD(pll_hold), .O_RX_OFF(rx_off), .O_LINK_DOWN(link_down),
		.O_AVG_RUN(avg_run));

	llh_pll_model i_llh_pll_model (
		.i_clk(clk), .i_srst(srst), .i_req(wr_req), .i_addr(wr_addr), .i_data(wr_data), .o_ack(ack),
		.o_wr_cnt(wr_cnt), .o_last_addr(last_addr), .o_last_data(last_data), .o_hold_word(hold_word),
		.o_rx_pd(rx_pd));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task complete_run();
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task wait_n(input int k);
		repeat (k) @(posedge clk);
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task wait_wr(input logic [15:0] a, input logic [31:0] d);
		n = wr_cnt;
		while (wr_cnt === n) @(posedge clk);
		check(32'(last_addr), 32'(a));
		check(last_data, d);
	endtask

	task wait_req();
		c = 0;
		while (wr_req !== 1'b1) begin
			@(posedge clk);
			c++;
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_regs();
		apb(1'b0, CTRL_OFS, 32'h0);
		check(rd, 32'h1);
		apb(1'b0, MON_LO_OFS, 32'h0);
		check(rd, 32'h00f0);
		apb(1'b0, MON_HI_OFS, 32'h0);
		check(rd, 32'h0110);
		apb(1'b1, STATUS_OFS, 32'hff);
		apb(1'b0, STATUS_OFS, 32'h0);
		check(32'(rd[8:0]), 32'h0);
		check(32'(err), 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		check(rd, 32'h0);
		check(32'(err), 32'h1);
	endtask

	task t_monitor();
		apb(1'b1, CTRL_OFS, 32'h3);
		wait_n(600);
		check(32'({link_down, avg_run}), 32'h1);
		apb(1'b1, MON_LO_OFS, 32'h00fa);
		wait_n(600);
		check(32'({link_down, avg_run}), 32'h2);
		apb(1'b1, MON_LO_OFS, 32'h00f9);
		wait_n(600);
		check(32'(link_down), 32'h0);
		tick <= 1'b0;
		wait_n(600);
		check(32'(link_down), 32'h1);
		tick <= 1'b1;
		wait_n(600);
		check(32'(link_down), 32'h0);
	endtask

	task t_refuse();
		apb(1'b1, CTRL_OFS, 32'h0);
		n = wr_cnt;
		nsl <= 1'b1;
		wait_n(30);
		check(32'({wr_cnt, pll_hold}), 32'({n, 1'b0}));
		nsl <= 1'b0;
		apb(1'b1, CTRL_OFS, 32'h3);
	endtask

	task t_hold();
		nsl <= 1'b1;
		wait_n(2);
		check(32'(avg_run), 32'h0);
		wait_wr(HOLD_CTRL_ADDR, 32'h3);
		nsl <= 1'b0;
		wait_n(2);
		check(32'({pll_hold, hold_word}), 32'h7);
		wait_wr(DES_PR_ADDR, 32'h1);
		wait_n(2);
		check(32'({rx_off, rx_pd}), 32'h3);
		wait_req();
		check(32'(c >= RXOFF_CYC - 10 && c <= RXOFF_CYC + 10), 32'h1);
		wait_wr(DES_PR_ADDR, 32'h0);
		wait_n(10);
		rx_ready <= 1'b0;
		wait_n(1);
		rx_ready <= 1'b1;
		wait_wr(DES_PR_ADDR, 32'h1);
		wait_wr(DES_PR_ADDR, 32'h0);
		wait_n(10);
		lane_lock <= 1'b0;
		wait_n(1);
		lane_lock <= 1'b1;
		wait_wr(DES_PR_ADDR, 32'h1);
		wait_wr(DES_PR_ADDR, 32'h0);
		wait_n(RXON_T + 20);
		apb(1'b0, STATUS_OFS, 32'h0);
		check(32'(rd[5:0]), 32'h16);
		flock <= 1'b1;
		wait_n(5);
		flock <= 1'b0;
		wait_n(VER_T + 10);
		apb(1'b0, STATUS_OFS, 32'h0);
		check(32'(rd[3:0]), 32'h6);
		flock <= 1'b1;
		wait_req();
		check(32'(c >= VER_T), 32'h1);
		wait_wr(HOLD_CTRL_ADDR, 32'h0);
		wait_n(2);
		check(32'({pll_hold, hold_word}), 32'h0);
		apb(1'b0, STATUS_OFS, 32'h0);
		check(32'(rd[3:0]), 32'h0);
	endtask

	// ----------------------------------------------------------------
	// Sequence and timeout
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			mismatches++;
			complete_run();
		end
	end

	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		t_regs();
		t_monitor();
		t_refuse();
		t_hold();
		complete_run();
	end
endmodule
